// ### design/srh_ctrl.sv
// Host-side controller driving a 256 x 4 asynchronous static CMOS RAM
//
// What this block does
// RULE1: RAM stores 256 four-bit words on an 8-bit address; data returns unchanged.
// RULE2: RAM is static; controller issues no refresh and no clock.
// RULE3: Standby select low forces RAM standby, blocking every access.
// RULE4: Retention begins on standby deassertion, with zero delay required.
// RULE5: Read data valid 850 ns after standby select asserted.
// RULE6: Outputs valid within 350 ns of output disable going low.
// RULE7: Outputs float within 150 ns of deselect or disable.
// RULE8: Read data is not trusted after an address change.
// RULE9: Read data is not trusted after chip select deasserts.
// RULE10: Standby select stays high 550 ns before write strobe ends.
// RULE11: Separate data paths allow output disable held low.
// RULE12: Shared data path holds output disable high through writes.
// RULE13: Write keeps address steady, 400 ns strobe, 400 ns setup, 100 ns hold.
// RULE14: Wait one 800 ns read cycle after leaving retention.
`timescale 1ns/1ns
`default_nettype none
`include "srh_map.svh"
module srh_ctrl
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire srh_pkg::srh_req_t req,
  output logic req_ready,
  input wire logic retain_req,
  output logic retain_active,
  output logic rd_valid,
  output logic [3:0] rd_data,
  output srh_pkg::srh_pins_t pins,
  output logic [3:0] ram_din,
  output logic ram_din_oe,
  input wire logic [3:0] ram_dout
);
  import srh_pkg::*;

  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam logic [3:0] RD_CYC = 4'(`SRH_CYC_MIN1(`SRH_T_CO2_NS));
  localparam logic [3:0] WP_CYC = 4'(`SRH_CYC_MIN1(`SRH_T_WP_NS));
  localparam logic [3:0] CW_CYC = 4'(`SRH_CYC_MIN1(`SRH_T_CW2_NS));
  localparam logic [3:0] SU_CYC = 4'(`SRH_CYC_MIN1(`SRH_T_AW_NS));
  localparam logic [3:0] DH_CYC = 4'(`SRH_CYC_MIN1(`SRH_T_DH_NS));
  localparam logic [3:0] DF_CYC = 4'(`SRH_CYC_MIN1(`SRH_T_DF_NS));
  localparam logic [3:0] RC_CYC = 4'(`SRH_CYC_MIN1(`SRH_T_RC_NS));

  typedef enum logic [2:0] {S_IDLE, S_RD, S_WSU, S_WP, S_WDH, S_FLOAT, S_RET, S_REC}
    srh_state_t;

  srh_state_t state_r;
  srh_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  // Both selects follow this one decode, so they never disagree
  function automatic logic in_access(input srh_state_t s);
    return s inside {S_RD, S_WSU, S_WP, S_WDH};
  endfunction

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r == 4'h0) ? 4'h0 : cnt_r - 4'h1;
    unique case (state_r)
      S_IDLE:
      begin
        if (retain_req)
        begin
          state_nxt = S_RET; // RULE4
        end
        else if (req_valid)
        begin
          state_nxt = req.write ? S_WSU : S_RD;
          // Standby select rises with the access, so the longer of the waits governs
          cnt_nxt = req.write ? ((CW_CYC > WP_CYC + SU_CYC) ? CW_CYC - WP_CYC : SU_CYC)
                              : RD_CYC; // RULE5 RULE10
        end
      end
      S_RD:
      begin
        if (cnt_r == 4'h1)
        begin
          state_nxt = S_FLOAT;
          cnt_nxt = DF_CYC; // RULE7
        end
      end
      S_WSU:
      begin
        if (cnt_r == 4'h1)
        begin
          state_nxt = S_WP;
          cnt_nxt = WP_CYC; // RULE13
        end
      end
      S_WP:
      begin
        if (cnt_r == 4'h1)
        begin
          state_nxt = S_WDH;
          cnt_nxt = DH_CYC; // RULE13
        end
      end
      S_WDH:
      begin
        if (cnt_r == 4'h1)
        begin
          state_nxt = S_FLOAT;
          cnt_nxt = DF_CYC;
        end
      end
      S_FLOAT:
      begin
        if (cnt_r == 4'h1)
        begin
          state_nxt = S_IDLE;
        end
      end
      S_RET:
      begin
        if (!retain_req)
        begin
          state_nxt = S_REC;
          cnt_nxt = RC_CYC; // RULE14
        end
      end
      S_REC:
      begin
        if (cnt_r == 4'h1)
        begin
          state_nxt = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // Request capture and pins
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ram_din <= 4'h0;
    end
    else if (state_r == S_IDLE && in_access(state_nxt))
    begin
      // Data is frozen for the whole cycle
      ram_din <= req.wdata; // RULE13
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins.addr <= 8'h00;
      pins.chip_select_active_low <= 1'b1;
      pins.standby_select <= 1'b0;
      pins.output_disable <= 1'b1;
      pins.write_strobe_n <= 1'b1;
      ram_din_oe <= 1'b0;
    end
    else
    begin
      // Standby select drops in idle, float, retention and recovery; no access runs then
      pins.standby_select <= in_access(state_nxt); // RULE3 RULE4
      pins.chip_select_active_low <= !in_access(state_nxt);
      // Address is frozen for the whole cycle; hold time after a move is zero
      if (state_r == S_IDLE && in_access(state_nxt))
      begin
        pins.addr <= req.addr; // RULE13
      end
      // Shared data bus assumed, so disable stays high across writes
      pins.output_disable <= (state_nxt != S_RD); // RULE6 RULE11 RULE12
      pins.write_strobe_n <= (state_nxt != S_WP); // RULE13
      ram_din_oe <= (state_nxt inside {S_WSU, S_WP, S_WDH}); // RULE13
    end
  end

  // ----------------------------------------
  // Read capture
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid <= 1'b0;
      rd_data <= 4'h0;
    end
    else
    begin
      // Sampled before address or select move, since hold time is zero
      rd_valid <= (state_r == S_RD && cnt_r == 4'h1); // RULE8 RULE9
      if (state_r == S_RD && cnt_r == 4'h1)
      begin
        rd_data <= ram_dout; // RULE1
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_ready <= 1'b0;
      retain_active <= 1'b0;
    end
    else
    begin
      req_ready <= (state_nxt == S_IDLE); // RULE2
      retain_active <= (state_nxt == S_RET);
    end
  end
endmodule
`default_nettype wire

// ### shared/srh_map.svh
// Timing constants and field layouts for the static RAM host controller
`ifndef SRH_MAP_SVH
`define SRH_MAP_SVH
`define SRH_CLK_NS 100
`define SRH_ADDR_W 8
`define SRH_DATA_W 4
`define SRH_DEPTH 256
`define SRH_T_RC_NS 800
`define SRH_T_CO2_NS 850
`define SRH_T_DIS_NS 350
`define SRH_T_DF_NS 150
`define SRH_T_CW2_NS 550
`define SRH_T_WP_NS 400
`define SRH_T_DW_NS 400
`define SRH_T_DH_NS 100
`define SRH_T_AW_NS 150
`define SRH_T_CDR_NS 0
`define SRH_CYC_UP(t) (((t) + `SRH_CLK_NS - 1) / `SRH_CLK_NS)
`define SRH_CYC_MIN1(t) ((`SRH_CYC_UP(t) < 1) ? 1 : `SRH_CYC_UP(t))
`define SRH_CNT_W 4
`endif

// ### shared/srh_pkg.sv
// Types for the static RAM host controller
package srh_pkg;
  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [3:0] wdata;
  } srh_req_t;
  typedef struct packed {
    logic chip_select_active_low;
    logic standby_select;
    logic output_disable;
    logic write_strobe_n;
    logic [7:0] addr;
  } srh_pins_t;
endpackage

// ### testbench/srh_ram_model.sv
// Behavioural 256 x 4 static RAM seen at the controller pins
`timescale 1ns/1ns
`default_nettype none
module srh_ram_model
(
  input wire srh_pkg::srh_pins_t pins,
  input wire logic [3:0] ram_din,
  input wire logic ram_din_oe,
  output logic [3:0] ram_dout
);
  import srh_pkg::*;
  logic [3:0] mem [256];
  realtime t0 = 0;
  wire live = !pins.chip_select_active_low && pins.standby_select;
  always @(pins.addr, live, pins.output_disable) t0 = $realtime;
  always @(posedge pins.write_strobe_n)
    if (live) mem[pins.addr] = ram_din_oe ? ram_din : ~ram_din;
  // Stale output toggles, so old data never passes for new
  initial
  begin
    ram_dout = 4'h0;
    #25;
    forever
    begin
      ram_dout = (live && !pins.output_disable && $realtime - t0 >= 850) ?
        mem[pins.addr] : ~ram_dout;
      #50;
    end
  end
endmodule
`default_nettype wire

// ### testbench/srh_ctrl_checker.sv
// Pin timing checks for the static RAM host controller
`timescale 1ns/1ns
`default_nettype none
module srh_ctrl_checker
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire srh_pkg::srh_req_t req,
  input wire logic req_ready,
  input wire logic retain_req,
  input wire logic retain_active,
  input wire logic rd_valid,
  input wire srh_pkg::srh_pins_t pins,
  input wire logic ram_din_oe
);
  import srh_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire we_n = pins.write_strobe_n;
  sequence s_take; req_valid && req_ready && !retain_req && !req.write; endsequence
  sequence s_strobe; !we_n [*4] ##1 we_n; endsequence
  a_disable_write: assert property (ram_din_oe |-> pins.output_disable)
    else $error("output enabled in write");
  a_strobe_width: assert property ($fell(we_n) |-> s_strobe)
    else $error("strobe width");
  a_stby_to_we: assert property ($rose(we_n) |-> $past(pins.standby_select, 6))
    else $error("select too late");
  a_data_held: assert property ($rose(we_n) |-> ram_din_oe && $past(ram_din_oe, 6))
    else $error("data setup or hold");
  a_addr_steady: assert property (!we_n |-> $stable(pins.addr))
    else $error("address moved");
  a_read_time: assert property (s_take |-> ##2 !rd_valid [*8] ##1 rd_valid)
    else $error("read answer time");
  a_read_select: assert property (rd_valid |-> $past(pins.standby_select, 9) &&
    $past(!pins.chip_select_active_low)) else $error("read sampled unselected");
  a_retain_stby: assert property (retain_active |-> !pins.standby_select)
    else $error("retention selected");
  a_recover_wait: assert property ($fell(retain_active) |-> !req_ready [*8])
    else $error("recovery short");
endmodule
bind srh_ctrl srh_ctrl_checker i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .retain_req(retain_req), .retain_active(retain_active),
  .rd_valid(rd_valid), .pins(pins), .ram_din_oe(ram_din_oe));
`default_nettype wire

// ### testbench/srh_ctrl_tb_top.sv
// Self-checking bench for the static RAM host controller
`timescale 1ns/1ns
`default_nettype none
module srh_ctrl_tb_top;
  import srh_pkg::*;
  logic clk_sys = 0, rst_n = 0, req_valid = 0, retain_req = 0;
  srh_req_t req = '0;
  logic req_ready, retain_active, rd_valid, ram_din_oe;
  logic [3:0] rd_data, ram_din, ram_dout;
  srh_pins_t pins;
  logic [3:0] shadow [256];
  logic [3:0] expq [$];
  int fails = 0, checks = 0, cyc = 0;
  integer seed = 32'h79fe876f;
  always #50 clk_sys = ~clk_sys;
  srh_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .retain_req(retain_req), .retain_active(retain_active),
    .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .ram_din(ram_din),
    .ram_din_oe(ram_din_oe), .ram_dout(ram_dout));
  srh_ram_model i_ram (.pins(pins), .ram_din(ram_din), .ram_din_oe(ram_din_oe),
    .ram_dout(ram_dout));
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Requests while busy are dropped, so wait for idle first
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] d);
    while (req_ready !== 1'b1)
    begin
      @(posedge clk_sys);
      #1;
    end
    req_valid = 1;
    req = '{w, a, d};
    if (w)
      shadow[a] = d;
    else
      expq.push_back(shadow[a]);
    @(posedge clk_sys);
    #1;
    req_valid = 0;
  endtask
  always @(posedge clk_sys)
  begin
    #2;
    cyc++;
    if (cyc > 15000)
    begin
      fails++;
      summarize();
    end
    else if (rd_valid === 1'b1)
    begin
      if (expq.size() == 0)
        check("stray read", 0, 1);
      else
        check("rd_data", expq.pop_front(), rd_data);
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1;
    for (int i = 0; i < 256; i++) access(1, 8'(i), 4'($random(seed)));
    for (int i = 0; i < 256; i++) access(0, 8'(i), 4'h0);
    $display("test fill and readback done");
    // Write offered during retention must be ignored
    retain_req = 1;
    req_valid = 1;
    req = '{1'b1, 8'h00, ~shadow[0]};
    repeat (20) @(posedge clk_sys);
    #1;
    check("retain_active", 1, retain_active);
    check("standby_select", 0, pins.standby_select);
    req_valid = 0;
    retain_req = 0;
    access(0, 8'h00, 4'h0);
    for (int i = 0; i < 8; i++) access(0, 8'($random(seed)), 4'h0);
    repeat (15) @(posedge clk_sys);
    check("queue empty", 0, expq.size());
    $display("test retention done");
    summarize();
  end
endmodule
`default_nettype wire
